// [include/rvm_pkg.sv]
package rvm_pkg;
   localparam int NREG    = 11;
   localparam int CODE_W  = 2;
   localparam int PCT_W   = 7;
   localparam int CNT_W   = 4;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int CODES_W = NREG * CODE_W;

   // Pin vector layout after synchronisation
   localparam int P_LOWC  = 0;
   localparam int P_HIGHC = CODES_W;
   localparam int P_LCMP  = 2 * CODES_W;
   localparam int P_HCMP  = P_LCMP + NREG;
   localparam int P_ON    = P_HCMP + NREG;
   localparam int P_INREG = P_ON + NREG;
   localparam int PIN_W   = P_INREG + NREG;

   // Slow logic tick derived from the bus clock
   localparam int                CLK_HZ    = 20_000_000;
   localparam int                SLOW_HZ   = 100_000;
   localparam int                TICK_DIV  = CLK_HZ / SLOW_HZ;
   localparam int                TICK_W    = 8;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
   localparam int                TICK_NS   = 1_000_000_000 / SLOW_HZ;

   localparam int LOW_FT_NS  [4] = '{5000, 15000, 25000, 40000};
   localparam int HIGH_FT_NS [4] = '{25000, 50000, 80000, 125000};

   // Register map
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MON_EN   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_KEY      = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h14;

   localparam int CTRL_LOW_LSB  = 0;
   localparam int CTRL_HIGH_LSB = 2;
   localparam int CTRL_SEC_BIT  = 4;
   localparam int HI_LSB        = 16;

   localparam logic [1:0]        LOW_FT_RST  = 2'h2;
   localparam logic [1:0]        HIGH_FT_RST = 2'h0;
   localparam logic [NREG-1:0]   MON_EN_RST  = 11'h7FF;
   // Unlock key value is arbitrary
   localparam logic [DATA_W-1:0] KEY_VALUE   = 32'h0000_C35A;
   localparam logic [3:0]        STRB_ALL    = 4'hF;
   localparam logic [1:0]        RESP_OKAY   = 2'h0;
   localparam logic [1:0]        RESP_SLVERR = 2'h2;

   localparam logic [PCT_W-1:0] LOW_PCT_BASE  = 7'h5F;
   localparam logic [PCT_W-1:0] HIGH_PCT_BASE = 7'h69;

   // One extra tick because the first tick may be partial
   function automatic logic [CNT_W-1:0] filter_ticks(input logic high, input logic [1:0] code);
      int ns;
      ns = high ? HIGH_FT_NS[code] : LOW_FT_NS[code];
      return CNT_W'((ns + TICK_NS - 1) / TICK_NS + 1);
   endfunction

   function automatic logic [PCT_W-1:0] trip_pct(input logic high, input logic [CODE_W-1:0] code);
      logic [PCT_W-1:0] step;
      step = {{(PCT_W-CODE_W-1){1'b0}}, code, 1'b0};
      return high ? HIGH_PCT_BASE + step : LOW_PCT_BASE - step;
   endfunction
endpackage

// [include/rvm_mon_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface rvm_mon_if;
   logic en;
   logic mask;
   logic low_cmp;
   logic high_cmp;
   logic low_flag;
   logic high_flag;
   modport ctl (output en, output mask, output low_cmp, output high_cmp,
                input low_flag, input high_flag);
   modport mon (input en, input mask, input low_cmp, input high_cmp,
                output low_flag, output high_flag);
endinterface
`default_nettype wire

// [core/rvm_mon_chan.sv]
`timescale 1ns/1ns
`default_nettype none
module rvm_mon_chan
   import rvm_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             tick,
   input  wire logic [CNT_W-1:0] low_lim,
   input  wire logic [CNT_W-1:0] high_lim,
   rvm_mon_if.mon                mon
);
   typedef struct packed {
      logic [CNT_W-1:0] low_cnt;
      logic [CNT_W-1:0] high_cnt;
      logic             low_flag;
      logic             high_flag;
   } rvm_chan_st_t;

   rvm_chan_st_t s_ff;
   rvm_chan_st_t nxt_s;

   // Returns {count, flag}
   function automatic logic [CNT_W:0] filt(input logic cmp, input logic tk,
                                           input logic [CNT_W-1:0] cnt,
                                           input logic flag, input logic [CNT_W-1:0] lim);
      logic [CNT_W-1:0] inc;
      inc = cnt + 1'b1;
      if (!cmp)
         return '0;
      else if (flag || !tk)
         return {cnt, flag};
      else if (inc == lim)
         return {cnt, 1'b1};
      else
         return {inc, 1'b0};
   endfunction

   always_comb
   begin
      nxt_s = s_ff;
      if (!mon.en)
      begin
         nxt_s = '0;
      end
      else if (mon.mask)
      begin
         nxt_s.low_cnt  = '0;
         nxt_s.high_cnt = '0;
      end
      else
      begin
         {nxt_s.low_cnt, nxt_s.low_flag}   = filt(mon.low_cmp, tick, s_ff.low_cnt,
                                                  s_ff.low_flag, low_lim);
         {nxt_s.high_cnt, nxt_s.high_flag} = filt(mon.high_cmp, tick, s_ff.high_cnt,
                                                  s_ff.high_flag, high_lim);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

   assign mon.low_flag  = s_ff.low_flag;
   assign mon.high_flag = s_ff.high_flag;

   AST_DISABLED_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
      !mon.en |=> !s_ff.low_flag && !s_ff.high_flag)
      else $error("flag kept while monitor disabled");

   AST_MASK_NO_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      mon.en && mon.mask && !s_ff.high_flag |=> !s_ff.high_flag)
      else $error("flag set while masked");

   AST_DROP_RESTARTS: assert property (@(posedge aclk) disable iff (!aresetn)
      mon.en && !mon.mask && !mon.low_cmp |=> s_ff.low_cnt == '0 && !s_ff.low_flag)
      else $error("count or flag kept after fault dropped");

   AST_SET_AFTER_FULL_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_ff.high_flag) |-> $past(tick) && $past(mon.high_cmp)
         && ($past(s_ff.high_cnt) == $past(high_lim) - 4'h1))
      else $error("flag set before filter time elapsed");
endmodule
`default_nettype wire

// [core/rvm_top.sv]
// Functional notes
// - Every one of the seven buck and four linear regulators has its own high and low monitor.
// - Low trip level is 95, 93, 91 or 89 percent of nominal for codes 00 to 11.
// - High trip level is 105, 107, 109 or 111 percent of nominal for codes 00 to 11.
// - One shared low filter setting selects 5, 15, 25 or 40 us for codes 00 to 11.
// - The shared low filter setting resets to 10.
// - One shared high filter setting selects 25, 50, 80 or 125 us for codes 00 to 11.
// - The shared high filter setting resets to 00.
// - A per-regulator enable bit turns that regulator's monitoring on at 1 and off at 0.
// - All enable bits come up as 1.
// - While secure writes are on, enable bits change only through the unlock procedure.
// - Detection is masked after a regulator turns on until it reaches regulation.
// - A disabled monitor forces its low and high flags to 0.
// - Filter timing runs on a 100 kHz logic tick.
`timescale 1ns/1ns
`default_nettype none
module rvm_top
   import rvm_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [ADDR_W-1:0]       awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [DATA_W-1:0]       wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [ADDR_W-1:0]       araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [DATA_W-1:0]            rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   input  wire logic [13:0]             buck_low_trip_code,
   input  wire logic [7:0]              linear_low_trip_code,
   input  wire logic [13:0]             buck_high_trip_code,
   input  wire logic [7:0]              linear_high_trip_code,
   input  wire logic [NREG-1:0]         low_cmp,
   input  wire logic [NREG-1:0]         high_cmp,
   input  wire logic [NREG-1:0]         reg_on,
   input  wire logic [NREG-1:0]         reg_in_regulation,
   output logic [NREG*PCT_W-1:0]        low_trip_pct,
   output logic [NREG*PCT_W-1:0]        high_trip_pct,
   output logic [NREG-1:0]              low_fault_flag,
   output logic [NREG-1:0]              high_fault_flag,
   output logic                         irq
);
   typedef struct packed {
      logic [PIN_W-1:0]        sync1;
      logic [PIN_W-1:0]        sync2;
      logic [NREG-1:0]         on_prev;
      logic [NREG-1:0]         mask;
      logic [TICK_W-1:0]       tick_cnt;
      logic                    tick;
      logic [1:0]              low_fault_filter_time;
      logic [1:0]              high_fault_filter_time;
      logic                    secure_en;
      logic                    unlock;
      logic [NREG-1:0]         monitor_enable;
      logic [NREG-1:0]         low_fault_flag;
      logic [NREG-1:0]         high_fault_flag;
      logic [NREG-1:0]         low_evt;
      logic [NREG-1:0]         high_evt;
      logic [NREG-1:0]         low_ie;
      logic [NREG-1:0]         high_ie;
      logic                    irq;
      logic [NREG*PCT_W-1:0]   low_trip_pct;
      logic [NREG*PCT_W-1:0]   high_trip_pct;
      logic                    aw_full;
      logic [ADDR_W-1:0]       aw_addr;
      logic                    w_full;
      logic [DATA_W-1:0]       wdata;
      logic [3:0]              wstrb;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [DATA_W-1:0]       rdata;
      logic [1:0]              rresp;
   } rvm_top_st_t;

   rvm_top_st_t       s_ff;
   rvm_top_st_t       nxt_s;
   logic              wr_go;
   logic [DATA_W-1:0] merged;
   logic [DATA_W-1:0] clr;
   logic [NREG-1:0]   chan_low;
   logic [NREG-1:0]   chan_high;
   logic [CNT_W-1:0]  low_lim;
   logic [CNT_W-1:0]  high_lim;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return a == OFS_CTRL || a == OFS_MON_EN || a == OFS_KEY || a == OFS_FLAGS
          || a == OFS_INT_STAT || a == OFS_INT_MASK;
   endfunction

   function automatic logic [DATA_W-1:0] bmask(input logic [3:0] strb);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < 4; b++)
         m[b*8 +: 8] = {8{strb[b]}};
      return m;
   endfunction

   function automatic logic [DATA_W-1:0] rd_word(input rvm_top_st_t st,
                                                 input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] w;
      w = '0;
      if (a == OFS_CTRL)
      begin
         w[CTRL_LOW_LSB +: 2]  = st.low_fault_filter_time;
         w[CTRL_HIGH_LSB +: 2] = st.high_fault_filter_time;
         w[CTRL_SEC_BIT]       = st.secure_en;
      end
      else if (a == OFS_MON_EN)
         w[NREG-1:0] = st.monitor_enable;
      else if (a == OFS_FLAGS)
      begin
         w[NREG-1:0]         = st.low_fault_flag;
         w[HI_LSB +: NREG]   = st.high_fault_flag;
      end
      else if (a == OFS_INT_STAT)
      begin
         w[NREG-1:0]         = st.low_evt;
         w[HI_LSB +: NREG]   = st.high_evt;
      end
      else if (a == OFS_INT_MASK)
      begin
         w[NREG-1:0]         = st.low_ie;
         w[HI_LSB +: NREG]   = st.high_ie;
      end
      return w;
   endfunction

   assign low_lim  = filter_ticks(1'b0, s_ff.low_fault_filter_time);
   assign high_lim = filter_ticks(1'b1, s_ff.high_fault_filter_time);

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.sync1 = {reg_in_regulation, reg_on, high_cmp, low_cmp,
                     linear_high_trip_code, buck_high_trip_code,
                     linear_low_trip_code, buck_low_trip_code};
      nxt_s.sync2 = s_ff.sync1;

      nxt_s.tick     = (s_ff.tick_cnt == TICK_LAST);
      nxt_s.tick_cnt = nxt_s.tick ? '0 : s_ff.tick_cnt + 1'b1;

      // Turn-on sets the mask, reaching regulation releases it
      nxt_s.on_prev = s_ff.sync2[P_ON +: NREG];
      nxt_s.mask    = (s_ff.mask | (s_ff.sync2[P_ON +: NREG] & ~s_ff.on_prev))
                    & ~s_ff.sync2[P_INREG +: NREG];

      for (int i = 0; i < NREG; i++)
      begin
         nxt_s.low_trip_pct[i*PCT_W +: PCT_W]  =
            trip_pct(1'b0, s_ff.sync2[P_LOWC + i*CODE_W +: CODE_W]);
         nxt_s.high_trip_pct[i*PCT_W +: PCT_W] =
            trip_pct(1'b1, s_ff.sync2[P_HIGHC + i*CODE_W +: CODE_W]);
      end

      nxt_s.low_fault_flag  = chan_low;
      nxt_s.high_fault_flag = chan_high;

      // Write channel
      if (awvalid && s_ff.awready)
      begin
         nxt_s.aw_full = 1'b1;
         nxt_s.aw_addr = awaddr;
      end
      if (wvalid && s_ff.wready)
      begin
         nxt_s.w_full = 1'b1;
         nxt_s.wdata  = wdata;
         nxt_s.wstrb  = wstrb;
      end
      if (bready && s_ff.bvalid)
         nxt_s.bvalid = 1'b0;

      wr_go  = s_ff.aw_full && s_ff.w_full && !s_ff.bvalid;
      merged = (rd_word(s_ff, s_ff.aw_addr) & ~bmask(s_ff.wstrb))
             | (s_ff.wdata & bmask(s_ff.wstrb));
      clr    = s_ff.wdata & bmask(s_ff.wstrb);
      if (wr_go)
      begin
         nxt_s.aw_full = 1'b0;
         nxt_s.w_full  = 1'b0;
         nxt_s.bvalid  = 1'b1;
         nxt_s.bresp   = RESP_OKAY;
         nxt_s.unlock  = 1'b0;
         if (s_ff.aw_addr == OFS_CTRL)
         begin
            nxt_s.low_fault_filter_time  = merged[CTRL_LOW_LSB +: 2];
            nxt_s.high_fault_filter_time = merged[CTRL_HIGH_LSB +: 2];
            nxt_s.secure_en              = merged[CTRL_SEC_BIT];
         end
         else if (s_ff.aw_addr == OFS_MON_EN)
         begin
            if (!s_ff.secure_en || s_ff.unlock)
               nxt_s.monitor_enable = merged[NREG-1:0];
         end
         else if (s_ff.aw_addr == OFS_KEY)
            nxt_s.unlock = (s_ff.wdata == KEY_VALUE) && (s_ff.wstrb == STRB_ALL);
         else if (s_ff.aw_addr == OFS_INT_STAT)
         begin
            nxt_s.low_evt  = s_ff.low_evt & ~clr[NREG-1:0];
            nxt_s.high_evt = s_ff.high_evt & ~clr[HI_LSB +: NREG];
         end
         else if (s_ff.aw_addr == OFS_INT_MASK)
         begin
            nxt_s.low_ie  = merged[NREG-1:0];
            nxt_s.high_ie = merged[HI_LSB +: NREG];
         end
         else if (!is_mapped(s_ff.aw_addr))
            nxt_s.bresp = RESP_SLVERR;
      end

      // New flags set events after the clear, so a set wins
      nxt_s.low_evt  = nxt_s.low_evt | (chan_low & ~s_ff.low_fault_flag);
      nxt_s.high_evt = nxt_s.high_evt | (chan_high & ~s_ff.high_fault_flag);
      nxt_s.irq      = |({nxt_s.high_evt, nxt_s.low_evt} & {nxt_s.high_ie, nxt_s.low_ie});
      nxt_s.awready  = !nxt_s.aw_full && !nxt_s.bvalid;
      nxt_s.wready   = !nxt_s.w_full && !nxt_s.bvalid;

      // Read channel
      if (rready && s_ff.rvalid)
         nxt_s.rvalid = 1'b0;
      if (arvalid && s_ff.arready)
      begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata  = rd_word(s_ff, araddr);
         nxt_s.rresp  = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      nxt_s.arready = !nxt_s.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_ff                        <= '0;
         s_ff.low_fault_filter_time  <= LOW_FT_RST;
         s_ff.high_fault_filter_time <= HIGH_FT_RST;
         s_ff.monitor_enable         <= MON_EN_RST;
      end
      else
         s_ff <= nxt_s;
   end

   rvm_mon_if mon_if[NREG] ();

   for (genvar g = 0; g < NREG; g++)
   begin : g_mon
      assign mon_if[g].en       = s_ff.monitor_enable[g];
      assign mon_if[g].mask     = s_ff.mask[g];
      assign mon_if[g].low_cmp  = s_ff.sync2[P_LCMP + g];
      assign mon_if[g].high_cmp = s_ff.sync2[P_HCMP + g];
      assign chan_low[g]        = mon_if[g].low_flag;
      assign chan_high[g]       = mon_if[g].high_flag;
      rvm_mon_chan u_chan (
         .aclk     (aclk),
         .aresetn  (aresetn),
         .tick     (s_ff.tick),
         .low_lim  (low_lim),
         .high_lim (high_lim),
         .mon      (mon_if[g].mon)
      );
   end

   assign awready         = s_ff.awready;
   assign wready          = s_ff.wready;
   assign bvalid          = s_ff.bvalid;
   assign bresp           = s_ff.bresp;
   assign arready         = s_ff.arready;
   assign rvalid          = s_ff.rvalid;
   assign rdata           = s_ff.rdata;
   assign rresp           = s_ff.rresp;
   assign low_trip_pct    = s_ff.low_trip_pct;
   assign high_trip_pct   = s_ff.high_trip_pct;
   assign low_fault_flag  = s_ff.low_fault_flag;
   assign high_fault_flag = s_ff.high_fault_flag;
   assign irq             = s_ff.irq;

   localparam int TICK_GAP = TICK_DIV;

   AST_RESET_LOW_FILTER: assert property (@(posedge aclk)
      $rose(aresetn) |-> s_ff.low_fault_filter_time == LOW_FT_RST)
      else $error("low filter time not reset to 10");

   AST_RESET_HIGH_FILTER: assert property (@(posedge aclk)
      $rose(aresetn) |-> s_ff.high_fault_filter_time == HIGH_FT_RST)
      else $error("high filter time not reset to 00");

   AST_RESET_ENABLES: assert property (@(posedge aclk)
      $rose(aresetn) |-> s_ff.monitor_enable == MON_EN_RST)
      else $error("monitor enables not all set after reset");

   AST_TICK_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
      s_ff.tick |-> ##[TICK_GAP:TICK_GAP] s_ff.tick)
      else $error("slow tick period wrong");

   AST_LOW_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
      !$rose(aresetn) |-> s_ff.low_trip_pct[PCT_W-1:0]
         == LOW_PCT_BASE - {$past(s_ff.sync2[P_LOWC +: CODE_W]), 1'b0})
      else $error("low trip percentage wrong");

   AST_HIGH_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
      !$rose(aresetn) |-> s_ff.high_trip_pct[PCT_W-1:0]
         == HIGH_PCT_BASE + {$past(s_ff.sync2[P_HIGHC +: CODE_W]), 1'b0})
      else $error("high trip percentage wrong");

   AST_SECURE_BLOCKS: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && s_ff.secure_en && !s_ff.unlock && s_ff.aw_addr == OFS_MON_EN
         |=> $stable(s_ff.monitor_enable))
      else $error("enable changed without unlock");

   AST_DISABLE_GATES: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_ff.monitor_enable[0] [*3] |-> !s_ff.low_fault_flag[0] && !s_ff.high_fault_flag[0])
      else $error("disabled monitor shows a flag");
endmodule
`default_nettype wire

// [sim/rvm_cmp_model.sv]
`timescale 1ns/1ns
`default_nettype none
module rvm_cmp_model
   import rvm_pkg::*;
(
   input  wire logic [NREG*PCT_W-1:0] low_trip_pct,
   input  wire logic [NREG*PCT_W-1:0] high_trip_pct,
   input  wire logic [7:0]            lvl [NREG],
   output logic [NREG-1:0]            low_cmp,
   output logic [NREG-1:0]            high_cmp
);
   // Output level in percent of nominal against each trip level
   always_comb
   begin
      for (int i = 0; i < NREG; i++)
      begin
         low_cmp[i]  = lvl[i] < {1'b0, low_trip_pct[i*PCT_W +: PCT_W]};
         high_cmp[i] = lvl[i] > {1'b0, high_trip_pct[i*PCT_W +: PCT_W]};
      end
   end
endmodule
`default_nettype wire

// [sim/rvm_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module rvm_top_tb;
   import rvm_pkg::*;
   logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic                  awready, wready, bvalid, arready, rvalid, irq;
   logic [ADDR_W-1:0]     awaddr, araddr;
   logic [DATA_W-1:0]     wdata, rdata;
   logic [3:0]            wstrb;
   logic [1:0]            bresp, rresp;
   logic [13:0]           buck_low_trip_code, buck_high_trip_code;
   logic [7:0]            linear_low_trip_code, linear_high_trip_code;
   logic [NREG-1:0]       low_cmp, high_cmp, reg_on, reg_in_regulation;
   logic [NREG-1:0]       low_fault_flag, high_fault_flag;
   logic [NREG*PCT_W-1:0] low_trip_pct, high_trip_pct;
   logic [7:0]            lvl [NREG];
   logic [3:0]            strb = STRB_ALL;
   int                    fails, compares, c, t;

   rvm_top rvm_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .buck_low_trip_code, .linear_low_trip_code, .buck_high_trip_code,
      .linear_high_trip_code, .low_cmp, .high_cmp, .reg_on, .reg_in_regulation, .low_trip_pct,
      .high_trip_pct, .low_fault_flag, .high_fault_flag, .irq);
   rvm_cmp_model rvm_cmp_model_i (.low_trip_pct, .high_trip_pct, .lvl, .low_cmp, .high_cmp);

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic test_done();
      if (fails == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tmo();
      fails++;
      $display("CHECK FAILED %0t wait timed out", $time);
      test_done();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      bit ad;
      bit wd;
      ad = 0;
      wd = 0;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= strb;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (n = 0; n < 50 && !(ad && wd && bvalid === 1'b1); n++)
      begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1)
            ad = 1;
         if (wvalid && wready === 1'b1)
            wd = 1;
         if (ad)
            awvalid <= 1'b0;
         if (wd)
            wvalid <= 1'b0;
      end
      if (n >= 50)
         tmo();
      chk(32'(bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      bit tk;
      tk = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 50 && !(tk && rvalid === 1'b1); n++)
      begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1)
         begin
            tk = 1;
            arvalid <= 1'b0;
         end
      end
      if (n >= 50)
         tmo();
      chk(rdata, e);
      chk(32'(rresp), 32'(er));
   endtask

   // Waits for a fault flag to reach a level, counting clocks
   task automatic wfl(input int r, input bit hi, input logic e, output int n);
      for (n = 0; n < 4000 && (hi ? high_fault_flag[r] : low_fault_flag[r]) !== e; n++)
         @(posedge aclk);
      if (n >= 4000)
         tmo();
   endtask

   initial
   begin
      aclk = 1'b0;
      forever
         #25 aclk = ~aclk;
   end

   initial
   begin
      {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb, aresetn} = '0;
      {buck_low_trip_code, linear_low_trip_code, buck_high_trip_code, linear_high_trip_code} = '0;
      {bready, rready, reg_on, reg_in_regulation} = '1;
      foreach (lvl[i])
         lvl[i] = 8'h64;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
      rd(OFS_MON_EN, 32'h0000_07FF, RESP_OKAY);
      rd(OFS_KEY, 32'h0, RESP_OKAY);
      wr(8'h40, 32'h1, RESP_SLVERR);
      rd(8'h40, 32'h0, RESP_SLVERR);
      for (int k = 0; k < 4; k++)
      begin
         {buck_low_trip_code, linear_low_trip_code} <= {11{k[1:0]}};
         {buck_high_trip_code, linear_high_trip_code} <= {11{k[1:0]}};
         repeat (5) @(posedge aclk);
         chk(32'(low_trip_pct[6:0]), 32'(8'h5F - 2 * k));
         chk(32'(low_trip_pct[76:70]), 32'(8'h5F - 2 * k));
         chk(32'(high_trip_pct[6:0]), 32'(8'h69 + 2 * k));
         chk(32'(high_trip_pct[76:70]), 32'(8'h69 + 2 * k));
      end
      {buck_low_trip_code, linear_low_trip_code, buck_high_trip_code, linear_high_trip_code} <= '0;
      repeat (5) @(posedge aclk);
      for (int h = 0; h < 2; h++)
         for (int k = 0; k < 4; k++)
         begin
            wr(OFS_CTRL, 32'(k << (2 * h)), RESP_OKAY);
            lvl[3 * k] <= (h == 1) ? 8'h78 : 8'h50;
            wfl(3 * k, h[0], 1'b1, c);
            t = (h == 1) ? HIGH_FT_NS[k] : LOW_FT_NS[k];
            chk(32'(c * 50 >= t && c * 50 <= t + 20500), 32'h1);
            lvl[3 * k] <= 8'h64;
            wfl(3 * k, h[0], 1'b0, c);
            chk(32'(c < 10), 32'h1);
         end
      chk(32'(irq), 32'h0);
      wr(OFS_INT_STAT, 32'h07FF_07FF, RESP_OKAY);
      wr(OFS_INT_MASK, 32'h0000_0001, RESP_OKAY);
      wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
      // Fault with a one clock dropout inside the filter time
      lvl[0] <= 8'h50;
      repeat (600) @(posedge aclk);
      lvl[0] <= 8'h64;
      @(posedge aclk);
      lvl[0] <= 8'h50;
      repeat (600) @(posedge aclk);
      chk(32'(low_fault_flag[0]), 32'h0);
      wfl(0, 1'b0, 1'b1, c);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h1);
      rd(OFS_INT_STAT, 32'h1, RESP_OKAY);
      rd(OFS_FLAGS, 32'h1, RESP_OKAY);
      lvl[0] <= 8'h64;
      repeat (10) @(posedge aclk);
      chk(32'(irq), 32'h1);
      wr(OFS_INT_STAT, 32'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0);
      // Only byte lane 2 written, other lanes keep their value
      strb = 4'h4;
      wr(OFS_INT_MASK, 32'hFFFF_FFFF, RESP_OKAY);
      strb = STRB_ALL;
      rd(OFS_INT_MASK, 32'h00FF_0001, RESP_OKAY);
      lvl[5] <= 8'h50;
      wfl(5, 1'b0, 1'b1, c);
      wr(OFS_CTRL, 32'h0000_0010, RESP_OKAY);
      wr(OFS_MON_EN, 32'h0000_07DF, RESP_OKAY);
      rd(OFS_MON_EN, 32'h0000_07FF, RESP_OKAY);
      wr(OFS_KEY, KEY_VALUE, RESP_OKAY);
      wr(OFS_MON_EN, 32'h0000_07DF, RESP_OKAY);
      rd(OFS_MON_EN, 32'h0000_07DF, RESP_OKAY);
      // Unlock is spent by one write
      wr(OFS_MON_EN, 32'h0000_07FF, RESP_OKAY);
      rd(OFS_MON_EN, 32'h0000_07DF, RESP_OKAY);
      chk(32'(low_fault_flag[5]), 32'h0);
      repeat (1500) @(posedge aclk);
      chk(32'(low_fault_flag[5]), 32'h0);
      wr(OFS_KEY, KEY_VALUE, RESP_OKAY);
      wr(OFS_MON_EN, 32'h0000_07FF, RESP_OKAY);
      wfl(5, 1'b0, 1'b1, c);
      chk(32'(c * 50 >= LOW_FT_NS[0] && c * 50 <= LOW_FT_NS[0] + 20500), 32'h1);
      lvl[5] <= 8'h64;
      reg_on[8] <= 1'b0;
      reg_in_regulation[8] <= 1'b0;
      repeat (5) @(posedge aclk);
      reg_on[8] <= 1'b1;
      lvl[8] <= 8'h50;
      repeat (1500) @(posedge aclk);
      chk(32'(low_fault_flag[8]), 32'h0);
      reg_in_regulation[8] <= 1'b1;
      wfl(8, 1'b0, 1'b1, c);
      chk(32'(c * 50 >= LOW_FT_NS[0] && c * 50 <= LOW_FT_NS[0] + 20500), 32'h1);
      test_done();
   end
endmodule
`default_nettype wire
